// ---- hw/ier_pkg.sv ----
// Purpose: Shared constants for the interrupt enable register block
// Assumes: 32-bit classic Wishbone, byte addresses, one word per register
// Notes:   Register data sits in the low byte; upper bits read as zero
package ier_pkg;

    localparam int unsigned DATA_W   = 32;
    localparam int unsigned ADDR_W   = 8;
    localparam int unsigned REG_W    = 8;
    localparam int unsigned PERIPH_N = 8;

    // Register byte offsets
    localparam logic [7:0] OFS_CORE_EN = 8'h00;
    localparam logic [7:0] OFS_PERI_EN = 8'h04;
    localparam logic [7:0] OFS_CTRL    = 8'h08;
    localparam logic [7:0] OFS_FLAG    = 8'h0C;
    localparam logic [7:0] OFS_STAT    = 8'h10;
    localparam logic [7:0] OFS_MASK    = 8'h14;

    // Core enable register fields
    localparam int unsigned CORE_T0_BIT  = 5;
    localparam int unsigned CORE_PC_BIT  = 4;
    localparam int unsigned CORE_EXT_BIT = 0;

    // Control register fields
    localparam int unsigned CTRL_GIE_BIT  = 7;
    localparam int unsigned CTRL_PERIPHERAL_GROUP_ENABLE_BIT = 6;
    localparam int unsigned CTRL_EDGE_BIT = 0;

    // Flag register fields
    localparam int unsigned FLAG_EXT_BIT = 0;

    // Event status / mask fields
    localparam int unsigned EV_EXT_EDGE = 0;
    localparam int unsigned EV_T0_HSET  = 1;
    localparam int unsigned EV_EXT_HSET = 2;
    localparam int unsigned EV_REQ_RISE = 3;
    localparam int unsigned EV_N        = 4;

    // Reset values
    localparam logic [7:0]      CORE_EN_RST = 8'h00;
    localparam logic [7:0]      PERI_EN_RST = 8'h00;
    localparam logic            GIE_RST     = 1'b0;
    localparam logic            PERIPHERAL_GROUP_ENABLE_RST    = 1'b0;
    localparam logic            EDGE_RST    = 1'b1;
    localparam logic [EV_N-1:0] EV_RST      = 4'h0;

endpackage

// ---- hw/ier_edge_detect.sv ----
// Purpose: Selectable rising or falling edge detector for one input
// Assumes: Input is synchronous to sys_clk
// Notes:   First sample after reset only primes the history, never fires
`timescale 1ns/1ns
`default_nettype none
module ier_edge_detect (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic rst_b,
    // Sampled level and edge choice
    input  wire logic level,
    input  wire logic riseSel,
    // One-cycle edge pulse
    output logic      edgePulse
);

    logic prevLevel_ff;
    logic primed_ff;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            prevLevel_ff <= 1'b0;
            primed_ff    <= 1'b0;
        end else begin
            prevLevel_ff <= level;
            primed_ff    <= 1'b1;
        end
    end

    always_comb begin
        if (!primed_ff) begin
            edgePulse = 1'b0;
        end else if (riseSel) begin
            edgePulse = level & ~prevLevel_ff;
        end else begin
            edgePulse = ~level & prevLevel_ff;
        end
    end

endmodule
`default_nettype wire

// ---- hw/ier_enable_regs.sv ----
// Purpose: Interrupt enable registers and request gating for a small core
// Assumes: Classic Wishbone slave, 32-bit data, answer one cycle after request
// Notes:   Source flags other than the external pin live in their peripherals
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - Core enable bits 7-6 are unimplemented and always read zero.
// - Core enable bit 5 gates the 8-bit timer overflow interrupt.
// - Core enable bit 4 gates the pin-change interrupt.
// - Core enable bit 0 gates the external pin interrupt.
// - Peripheral interrupts pass only with the peripheral group enable set.
// - Eight read-write peripheral enable bits, all zero after reset.
// - Timer and external enables writable and hardware-settable; pin-change read-only.
// - External pin edge: rising when edge select is one, else falling.
// - Valid external edge sets its flag; vectoring needs global and pin enable.
// - Global enable clear blocks requests; pending ones serve when re-enabled.
module ier_enable_regs #(
    parameter int unsigned PERIPH_N = ier_pkg::PERIPH_N,
    parameter int unsigned DATA_W   = ier_pkg::DATA_W
) (
    // Clock and reset
    input  wire logic                sys_clk,
    input  wire logic                rst_b,
    // Wishbone slave
    input  wire logic                cyc_i,
    input  wire logic                stb_i,
    input  wire logic                we_i,
    input  wire logic [7:0]          adr_i,
    input  wire logic [3:0]          sel_i,
    input  wire logic [DATA_W-1:0]   dat_i,
    output logic      [DATA_W-1:0]   dat_o,
    output logic                     ack_o,
    // External interrupt pin
    input  wire logic                extPin,
    // Hardware sets of enables and pin-change enable source
    input  wire logic                timer0EnableSet,
    input  wire logic                extEnableSet,
    input  wire logic                pinChangeEnableIn,
    // Source flags from peripherals
    input  wire logic                timer0Flag,
    input  wire logic                pinChangeFlag,
    input  wire logic [PERIPH_N-1:0] periphFlags,
    // Core vectoring handshake
    input  wire logic                coreVectorTaken,
    input  wire logic                coreReturn,
    // Outputs
    output logic                     coreIrqReq,
    output logic [PERIPH_N-1:0]      periphEnables,
    output logic                     irq
);

    generate
        if (PERIPH_N != ier_pkg::REG_W) begin : g_bad_n
            $error("PERIPH_N must equal the register width");
        end
        if (DATA_W != ier_pkg::DATA_W) begin : g_bad_w
            $error("DATA_W must be 32");
        end
    endgenerate

    // Register state
    logic                      timer0En_ff;
    logic                      pinChangeEn_ff;
    logic                      extEn_ff;
    logic [PERIPH_N-1:0]       periEn_ff;
    logic                      globalEn_ff;
    logic                      periGroupEn_ff;
    logic                      edgeSel_ff;
    logic                      extFlag_ff;
    logic [ier_pkg::EV_N-1:0]  evStat_ff;
    logic [ier_pkg::EV_N-1:0]  evMask_ff;
    logic                      ack_ff;
    logic [DATA_W-1:0]         rdData_ff;
    logic                      coreReq_ff;

    // Bus decode
    logic                      access;
    logic                      wrLow;
    logic                      rdAccess;
    logic [7:0]                wrByte;
    logic [7:0]                rdByte;
    logic                      hitCore;
    logic                      hitPeri;
    logic                      hitCtrl;
    logic                      hitFlag;
    logic                      hitStat;
    logic                      hitMask;

    // Internal terms
    logic                      extEdge;
    logic                      periTerm;
    logic                      nxt_coreReq;
    logic [ier_pkg::EV_N-1:0]  evSet;

    assign access   = cyc_i & stb_i & ~ack_ff;
    assign wrLow    = access & we_i & sel_i[0];
    assign rdAccess = access & ~we_i;
    assign wrByte   = dat_i[7:0];

    assign hitCore = (adr_i == ier_pkg::OFS_CORE_EN);
    assign hitPeri = (adr_i == ier_pkg::OFS_PERI_EN);
    assign hitCtrl = (adr_i == ier_pkg::OFS_CTRL);
    assign hitFlag = (adr_i == ier_pkg::OFS_FLAG);
    assign hitStat = (adr_i == ier_pkg::OFS_STAT);
    assign hitMask = (adr_i == ier_pkg::OFS_MASK);

    // External pin edge detection
    ier_edge_detect u_ext_edge (
        .sys_clk   (sys_clk),
        .rst_b     (rst_b),
        .level     (extPin),
        .riseSel   (edgeSel_ff),
        .edgePulse (extEdge)
    );

    // Core enable register: timer0 and external enables
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            timer0En_ff <= ier_pkg::CORE_EN_RST[ier_pkg::CORE_T0_BIT];
            extEn_ff    <= ier_pkg::CORE_EN_RST[ier_pkg::CORE_EXT_BIT];
        end else begin
            if (timer0EnableSet) begin
                timer0En_ff <= 1'b1;
            end else if (wrLow && hitCore) begin
                timer0En_ff <= wrByte[ier_pkg::CORE_T0_BIT];
            end
            if (extEnableSet) begin
                extEn_ff <= 1'b1;
            end else if (wrLow && hitCore) begin
                extEn_ff <= wrByte[ier_pkg::CORE_EXT_BIT];
            end
        end
    end

    // Pin-change enable follows its source, never software
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pinChangeEn_ff <= ier_pkg::CORE_EN_RST[ier_pkg::CORE_PC_BIT];
        end else begin
            pinChangeEn_ff <= pinChangeEnableIn;
        end
    end

    // Peripheral enable register
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            periEn_ff <= ier_pkg::PERI_EN_RST;
        end else if (wrLow && hitPeri) begin
            periEn_ff <= wrByte[PERIPH_N-1:0];
        end
    end

    // Control register: group enable and edge select
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            periGroupEn_ff <= ier_pkg::PERIPHERAL_GROUP_ENABLE_RST;
            edgeSel_ff     <= ier_pkg::EDGE_RST;
        end else if (wrLow && hitCtrl) begin
            periGroupEn_ff <= wrByte[ier_pkg::CTRL_PERIPHERAL_GROUP_ENABLE_BIT];
            edgeSel_ff     <= wrByte[ier_pkg::CTRL_EDGE_BIT];
        end
    end

    // Global enable: cleared on vector entry, set on return or by software
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            globalEn_ff <= ier_pkg::GIE_RST;
        end else if (coreReturn) begin
            globalEn_ff <= 1'b1;
        end else if (wrLow && hitCtrl) begin
            globalEn_ff <= wrByte[ier_pkg::CTRL_GIE_BIT];
        end else if (coreVectorTaken) begin
            globalEn_ff <= 1'b0;
        end
    end

    // External pin flag: edge sets regardless of enables, write-one clears
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            extFlag_ff <= 1'b0;
        end else if (extEdge) begin
            extFlag_ff <= 1'b1;
        end else if (wrLow && hitFlag && wrByte[ier_pkg::FLAG_EXT_BIT]) begin
            extFlag_ff <= 1'b0;
        end
    end

    // Request combination
    assign periTerm = periGroupEn_ff & |(periphFlags & periEn_ff);

    assign nxt_coreReq = globalEn_ff &
                         ((timer0Flag    & timer0En_ff)
                        | (pinChangeFlag & pinChangeEn_ff)
                        | (extFlag_ff    & extEn_ff)
                        | periTerm);

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            coreReq_ff <= 1'b0;
        end else begin
            coreReq_ff <= nxt_coreReq;
        end
    end

    // Event status: sticky, read clears, set wins over the clear
    always_comb begin
        evSet                       = '0;
        evSet[ier_pkg::EV_EXT_EDGE] = extEdge;
        evSet[ier_pkg::EV_T0_HSET]  = timer0EnableSet;
        evSet[ier_pkg::EV_EXT_HSET] = extEnableSet;
        evSet[ier_pkg::EV_REQ_RISE] = nxt_coreReq & ~coreReq_ff;
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            evStat_ff <= ier_pkg::EV_RST;
        end else if (rdAccess && hitStat) begin
            evStat_ff <= evSet;
        end else begin
            evStat_ff <= evStat_ff | evSet;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            evMask_ff <= ier_pkg::EV_RST;
        end else if (wrLow && hitMask) begin
            evMask_ff <= wrByte[ier_pkg::EV_N-1:0];
        end
    end

    // Read mux; unmapped offsets read zero
    always_comb begin
        rdByte = '0;
        if (hitCore) begin
            rdByte[ier_pkg::CORE_T0_BIT]  = timer0En_ff;
            rdByte[ier_pkg::CORE_PC_BIT]  = pinChangeEn_ff;
            rdByte[ier_pkg::CORE_EXT_BIT] = extEn_ff;
        end else if (hitPeri) begin
            rdByte[PERIPH_N-1:0] = periEn_ff;
        end else if (hitCtrl) begin
            rdByte[ier_pkg::CTRL_GIE_BIT]  = globalEn_ff;
            rdByte[ier_pkg::CTRL_PERIPHERAL_GROUP_ENABLE_BIT] = periGroupEn_ff;
            rdByte[ier_pkg::CTRL_EDGE_BIT] = edgeSel_ff;
        end else if (hitFlag) begin
            rdByte[ier_pkg::FLAG_EXT_BIT] = extFlag_ff;
        end else if (hitStat) begin
            rdByte[ier_pkg::EV_N-1:0] = evStat_ff;
        end else if (hitMask) begin
            rdByte[ier_pkg::EV_N-1:0] = evMask_ff;
        end
    end

    // Bus answer one cycle after the request, dropped the cycle after
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ack_ff    <= 1'b0;
            rdData_ff <= '0;
        end else begin
            ack_ff <= access;
            if (rdAccess) begin
                rdData_ff <= {{(DATA_W-8){1'b0}}, rdByte};
            end
        end
    end

    assign ack_o         = ack_ff;
    assign dat_o         = rdData_ff;
    assign coreIrqReq    = coreReq_ff;
    assign periphEnables = periEn_ff;
    assign irq           = |(evStat_ff & evMask_ff);

endmodule
`default_nettype wire

// ---- verification/ier_regs_checker.sv ----
// Purpose: Port assertions for the enable register block
// Assumes: One sys_clk domain, async active-low reset
// Notes:   Global enable is mirrored from bus and core handshake
`timescale 1ns/1ns
`default_nettype none
module ier_regs_checker #(
    parameter int unsigned PERIPH_N = 8,
    parameter int unsigned DATA_W   = 32
) (
    // Clock, reset and bus
    input wire logic                sys_clk,
    input wire logic                rst_b,
    input wire logic                cyc_i,
    input wire logic                stb_i,
    input wire logic                we_i,
    input wire logic [7:0]          adr_i,
    input wire logic [3:0]          sel_i,
    input wire logic [DATA_W-1:0]   dat_i,
    input wire logic [DATA_W-1:0]   dat_o,
    input wire logic                ack_o,
    // Core side
    input wire logic                pinChangeEnableIn,
    input wire logic                coreVectorTaken,
    input wire logic                coreReturn,
    input wire logic                coreIrqReq,
    input wire logic [PERIPH_N-1:0] periphEnables,
    input wire logic                irq
);
    logic take;
    logic gieTrack_ff;
    assign take = cyc_i && stb_i && !ack_o;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            gieTrack_ff <= 1'b0;
        end else if (coreReturn) begin
            gieTrack_ff <= 1'b1;
        end else if (take && we_i && sel_i[0]
                     && adr_i == ier_pkg::OFS_CTRL) begin
            gieTrack_ff <= dat_i[7];
        end else if (coreVectorTaken) begin
            gieTrack_ff <= 1'b0;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    AST_ACK_NEXT:
        assert property (take |=> ack_o) else $error("no ack");
    AST_ACK_PULSE:
        assert property (ack_o |=> !ack_o) else $error("ack held");
    AST_HIGH_ZERO:
        assert property (ack_o |-> dat_o[31:8] == 24'h000000)
        else $error("upper read bits set");
    AST_CORE_RSVD:
        assert property (take && !we_i && adr_i == ier_pkg::OFS_CORE_EN
            |=> dat_o[7:6] == 2'h0 && dat_o[3:1] == 3'h0)
        else $error("unimplemented bits read one");
    AST_PC_RO:
        assert property (take && !we_i && adr_i == ier_pkg::OFS_CORE_EN
            |=> dat_o[4] == $past(pinChangeEnableIn, 2))
        else $error("pin-change enable wrong");
    AST_PERI_COPY:
        assert property (take && we_i && sel_i[0]
            && adr_i == ier_pkg::OFS_PERI_EN
            |-> ##2 periphEnables == $past(dat_i[PERIPH_N-1:0], 2))
        else $error("peripheral enables not written");
    AST_GIE_GATE:
        assert property (!gieTrack_ff |=> !coreIrqReq)
        else $error("request with global enable clear");
    AST_RST_QUIET:
        assert property ($rose(rst_b) |-> !ack_o && !coreIrqReq
            && !irq && periphEnables == 8'h00)
        else $error("outputs active after reset");
endmodule
bind ier_enable_regs ier_regs_checker #(
    .PERIPH_N(PERIPH_N),
    .DATA_W  (DATA_W)
) i_chk (.sys_clk, .rst_b, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
    .dat_i, .dat_o, .ack_o, .pinChangeEnableIn, .coreVectorTaken,
    .coreReturn, .coreIrqReq, .periphEnables, .irq);
`default_nettype wire

// ---- verification/ier_core_model.sv ----
// Purpose: Core partner that vectors on the combined request
// Assumes: Return is commanded by the bench
// Notes:   Stays in service until return, one vector per request
`timescale 1ns/1ns
`default_nettype none
module ier_core_model (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst_b,
    // Request and bench commands
    input  wire logic       coreIrqReq,
    input  wire logic       retReq,
    input  wire logic [3:0] delay,
    // Handshake back
    output logic            coreVectorTaken,
    output logic            coreReturn,
    output logic [7:0]      vecCount
);
    logic [3:0] wait_ff;
    logic       inIsr_ff;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            wait_ff         <= 4'h0;
            inIsr_ff        <= 1'b0;
            coreVectorTaken <= 1'b0;
            coreReturn      <= 1'b0;
            vecCount        <= 8'h00;
        end else begin
            coreVectorTaken <= 1'b0;
            coreReturn      <= retReq;
            if (retReq) begin
                inIsr_ff <= 1'b0;
                wait_ff  <= 4'h0;
            end else if (coreIrqReq && !inIsr_ff) begin
                wait_ff <= wait_ff + 4'h1;
                if (wait_ff == delay) begin
                    coreVectorTaken <= 1'b1;
                    inIsr_ff        <= 1'b1;
                    vecCount        <= vecCount + 8'h01;
                end
            end else begin
                wait_ff <= 4'h0;
            end
        end
    end
endmodule
`default_nettype wire

// ---- verification/test_ier_enable_regs.sv ----
// Purpose: Register and request path tests
// Assumes: Bench drives source flags in place of peripherals
// Notes:   Vector counts come from the core model
`timescale 1ns/1ns
`default_nettype none
module test_ier_enable_regs;
    logic        sys_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] dat = 32'h0;
    logic [3:0]  sel = 4'hF;
    logic [31:0] rdat;
    logic        ack;
    logic        extPin = 1'b0;
    logic        t0Set = 1'b0;
    logic        extSet = 1'b0;
    logic        pce = 1'b0;
    logic        t0Flag = 1'b0;
    logic        pcFlag = 1'b0;
    logic [7:0]  pf = 8'h00;
    logic        retReq = 1'b0;
    logic [3:0]  delay = 4'h0;
    logic        vTaken, cRet, req, irq;
    logic [7:0]  pEn, vecCount;
    int          miscompares = 0;
    int          checked = 0;
    always #5 sys_clk = ~sys_clk;
    ier_enable_regs i_dut (.sys_clk(sys_clk), .rst_b(rst_b), .cyc_i(cyc),
        .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat),
        .dat_o(rdat), .ack_o(ack), .extPin(extPin), .timer0EnableSet(t0Set),
        .extEnableSet(extSet), .pinChangeEnableIn(pce), .timer0Flag(t0Flag),
        .pinChangeFlag(pcFlag), .periphFlags(pf), .coreVectorTaken(vTaken),
        .coreReturn(cRet), .coreIrqReq(req), .periphEnables(pEn), .irq(irq));
    ier_core_model i_core (.sys_clk(sys_clk), .rst_b(rst_b),
        .coreIrqReq(req), .retReq(retReq), .delay(delay),
        .coreVectorTaken(vTaken), .coreReturn(cRet), .vecCount(vecCount));
    task automatic report_and_stop;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // Classic cycle; m selects checked read bits, zero for writes
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [7:0] d, input logic [7:0] m);
        logic [31:0] v;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= {24'h000000, d};
        do @(posedge sys_clk); while (ack !== 1'b1);
        v = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (!w && m != 8'h00) cmp(v & {24'hFFFFFF, m}, {24'h0, d & m});
        @(posedge sys_clk);
    endtask
    task automatic retPulse;
        retReq <= 1'b1;
        @(posedge sys_clk);
        retReq <= 1'b0;
        repeat (20) @(posedge sys_clk);
    endtask
    // src: bit0 timer flag, bit1 pin-change flag, bit2 peripheral flag
    task automatic srcCase(input logic [7:0] core, input logic [7:0] ctl,
                           input logic [2:0] src, input logic [7:0] e);
        bus(1'b1, ier_pkg::OFS_CORE_EN, core, 8'h00);
        bus(1'b1, ier_pkg::OFS_CTRL, ctl, 8'h00);
        t0Flag <= src[0];
        pcFlag <= src[1];
        pf <= src[2] ? 8'h80 : 8'h00;
        repeat (20) @(posedge sys_clk);
        cmp({24'h0, vecCount}, {24'h0, e});
        t0Flag <= 1'b0;
        pcFlag <= 1'b0;
        pf <= 8'h00;
        retPulse();
    endtask
    initial begin
        repeat (5000) @(posedge sys_clk);
        miscompares++;
        report_and_stop();
    end
    initial begin
        repeat (10) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        bus(1'b0, ier_pkg::OFS_CORE_EN, 8'h00, 8'hFF);
        bus(1'b0, ier_pkg::OFS_PERI_EN, 8'h00, 8'hFF);
        bus(1'b0, ier_pkg::OFS_CTRL, 8'h01, 8'hFF);
        bus(1'b1, ier_pkg::OFS_CORE_EN, 8'hFF, 8'h00);
        bus(1'b0, ier_pkg::OFS_CORE_EN, 8'h21, 8'hFF);
        pce <= 1'b1;
        @(posedge sys_clk);
        bus(1'b0, ier_pkg::OFS_CORE_EN, 8'h31, 8'hFF);
        for (int i = 0; i < 8; i++) begin
            bus(1'b1, ier_pkg::OFS_PERI_EN, 8'h01 << i, 8'h00);
            bus(1'b0, ier_pkg::OFS_PERI_EN, 8'h01 << i, 8'hFF);
            cmp({24'h0, pEn}, {24'h0, 8'h01 << i});
        end
        // Write with the low byte lane off must change nothing
        sel <= 4'hE;
        bus(1'b1, ier_pkg::OFS_PERI_EN, 8'h00, 8'h00);
        sel <= 4'hF;
        bus(1'b0, ier_pkg::OFS_PERI_EN, 8'h80, 8'hFF);
        cmp({24'h0, pEn}, 32'h80);
        bus(1'b1, 8'h40, 8'hFF, 8'h00);
        bus(1'b0, 8'h40, 8'h00, 8'hFF);
        srcCase(8'h00, 8'h81, 3'h1, 8'h00);
        srcCase(8'h20, 8'h81, 3'h1, 8'h01);
        srcCase(8'h20, 8'h01, 3'h1, 8'h01);
        srcCase(8'h00, 8'h81, 3'h2, 8'h02);
        srcCase(8'h00, 8'h81, 3'h4, 8'h02);
        delay <= 4'h5;
        srcCase(8'h00, 8'hC1, 3'h4, 8'h03);
        pce <= 1'b0;
        srcCase(8'h00, 8'hC1, 3'h2, 8'h03);
        bus(1'b0, ier_pkg::OFS_STAT, 8'h00, 8'h00);
        t0Set <= 1'b1;
        extSet <= 1'b1;
        @(posedge sys_clk);
        t0Set <= 1'b0;
        extSet <= 1'b0;
        bus(1'b0, ier_pkg::OFS_CORE_EN, 8'h21, 8'hFF);
        bus(1'b0, ier_pkg::OFS_STAT, 8'h06, 8'h06);
        bus(1'b1, ier_pkg::OFS_MASK, 8'h01, 8'h00);
        bus(1'b1, ier_pkg::OFS_CTRL, 8'h80, 8'h00);
        extPin <= 1'b1;
        repeat (3) @(posedge sys_clk);
        bus(1'b0, ier_pkg::OFS_FLAG, 8'h00, 8'hFF);
        extPin <= 1'b0;
        repeat (3) @(posedge sys_clk);
        cmp({31'h0, irq}, 32'h1);
        bus(1'b0, ier_pkg::OFS_FLAG, 8'h01, 8'hFF);
        repeat (20) @(posedge sys_clk);
        cmp({24'h0, vecCount}, 32'h4);
        retPulse();
        cmp({24'h0, vecCount}, 32'h5);
        bus(1'b0, ier_pkg::OFS_STAT, 8'h01, 8'h01);
        cmp({31'h0, irq}, 32'h0);
        bus(1'b0, ier_pkg::OFS_STAT, 8'h00, 8'h0F);
        // Write-one clear of the pin flag, then a rising edge
        bus(1'b1, ier_pkg::OFS_FLAG, 8'h01, 8'h00);
        bus(1'b0, ier_pkg::OFS_FLAG, 8'h00, 8'hFF);
        bus(1'b1, ier_pkg::OFS_CTRL, 8'h01, 8'h00);
        extPin <= 1'b1;
        repeat (3) @(posedge sys_clk);
        bus(1'b0, ier_pkg::OFS_FLAG, 8'h01, 8'hFF);
        report_and_stop();
    end
endmodule
`default_nettype wire
